// ### shared/lfte_defs.svh
// Offsets, field positions, reset values and codes of the link feature tuning block
`ifndef LFTE_DEFS_SVH
`define LFTE_DEFS_SVH

// Register map (byte address on the configuration port)
`define LFTE_LINK_FEATURE_TUNING_OFS 8'hf4
`define LFTE_LINK_FEATURE_TUNING_RST 32'h00001000
`define LFTE_LINK_FEATURE_TUNING_WMASK 32'h00003086

// Field positions
`define LFTE_THRESH_HI 13
`define LFTE_THRESH_LO 12
`define LFTE_PRIO_BIT 7
`define LFTE_PERMIT_BIT 6
`define LFTE_IDLE_BIT 2
`define LFTE_ACCEL_BIT 1

// Threshold codes
`define LFTE_THR_2K 2'h0
`define LFTE_THR_1K7 2'h1
`define LFTE_THR_1K 2'h2
`define LFTE_THR_512 2'h3

// Nominal start levels in bytes, scaled onto the real queue depth
`define LFTE_THR_2K_BYTES 2048
`define LFTE_THR_1K7_BYTES 1700
`define LFTE_THR_1K_BYTES 1024
`define LFTE_THR_512_BYTES 512
`define LFTE_QUEUE_NOMINAL_BYTES 2048

// Control line codes
`define LFTE_CT_GRANT 2'h3
`define LFTE_CT_XMIT 2'h2

`endif

// ### shared/lfte_pkg.sv
// Types shared by the link feature tuning block
`default_nettype none

package lfte_pkg;

   typedef enum logic [5:0] {
      st_idle    = 6'h01,
      st_req     = 6'h02,
      st_turn    = 6'h04,
      st_drive   = 6'h08,
      st_fin     = 6'h10,
      st_discard = 6'h20
   } lfte_state_t;

endpackage

`default_nettype wire

// ### core/lfte_fifo.sv
// Transmit queue: parameterised FIFO with valid/ready on both sides
`timescale 1ns/10ps
`default_nettype none

module lfte_fifo #(
   parameter int WIDTH = 33,
   parameter int DEPTH = 16
) (
   input  wire logic                       clk_in,
   input  wire logic                       rst_in,
   input  wire logic                       in_valid_in,
   output logic                            in_ready_out,
   input  wire logic [WIDTH-1:0]           in_data_in,
   output logic                            out_valid_out,
   input  wire logic                       out_ready_in,
   output logic [WIDTH-1:0]                out_data_out,
   output logic [$clog2(DEPTH):0]          level_out
);
   localparam int AW = $clog2(DEPTH);
   localparam int CW = AW + 1;

   // DEPTH must be a power of two so the pointers wrap by themselves
   typedef struct packed {
      logic [AW-1:0] wr_ptr;
      logic [AW-1:0] rd_ptr;
      logic [CW-1:0] count;
      logic          ready;
      logic          avail;
   } lfte_fifo_state_t;

   lfte_fifo_state_t s_reg;
   lfte_fifo_state_t s_next;
   logic [WIDTH-1:0] mem [DEPTH];
   logic             push;
   logic             pop;

   assign push = in_valid_in && s_reg.ready;
   assign pop  = out_ready_in && s_reg.avail;

   always_comb begin
      s_next = s_reg;
      if (push) begin
         s_next.wr_ptr = s_reg.wr_ptr + 1'b1;
      end
      if (pop) begin
         s_next.rd_ptr = s_reg.rd_ptr + 1'b1;
      end
      s_next.count = s_reg.count + CW'(push) - CW'(pop);
      s_next.ready = (s_next.count != CW'(DEPTH));
      s_next.avail = (s_next.count != '0);
   end

   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         s_reg <= '{wr_ptr: '0, rd_ptr: '0, count: '0, ready: 1'b1, avail: 1'b0};
      end else begin
         s_reg <= s_next;
      end
   end

   // Storage carries no reset; only words behind a valid count are ever read
   always_ff @(posedge clk_in) begin
      if (push) begin
         mem[s_reg.wr_ptr] <= in_data_in;
      end
   end

   assign in_ready_out  = s_reg.ready;
   assign out_valid_out = s_reg.avail;
   assign out_data_out  = mem[s_reg.rd_ptr];
   assign level_out     = s_reg.count;

endmodule // lfte_fifo

`default_nettype wire

// ### core/lfte_ctrl.sv
// Link feature tuning register with transmit start control and link turnaround
//
// What this block does
// - Enhancement settings act only while the PHY enhancement gate input is set.
// - Register loads from host writes or from the serial configuration ROM.
// - Bits 13-12 pick start level: 2K, 1.7K (reset), 1K, 512 bytes.
// - After an underrun the retried packet uses the 2K store-and-forward level.
// - Below 2K, start at threshold level or once a whole packet is queued.
// - Queue draining mid-packet is an underrun, the packet is abandoned.
// - At 2K, start only after the end-of-packet word is queued.
// - Bit 7 enables priority arbitration requests.
// - Bit 2 inserts one idle cycle after grant before driving lines.
// - PHY hands over lines by driving 11b; without idle, drive at once.
// - Bit 1 advertises acceleration support to the PHY.
// - Reserved bits read zero and ignore writes.
// - Bit 6 reads zero; its ROM value drives the programming permit.
`timescale 1ns/10ps
`default_nettype none
`include "lfte_defs.svh"

module lfte_ctrl
   import lfte_pkg::*;
#(
   parameter int DATA_W = 32,
   parameter int DEPTH  = 16
) (
   input  wire logic              clk_in,
   input  wire logic              rst_in,
   input  wire logic [7:0]        cfg_addr_in,
   input  wire logic              cfg_wr_in,
   input  wire logic              cfg_rd_in,
   input  wire logic [31:0]       cfg_wdata_in,
   output logic [31:0]            cfg_rdata_out,
   input  wire logic              rom_load_in,
   input  wire logic [31:0]       rom_word_in,
   input  wire logic              phy_enhancement_gate_in,
   output logic                   phy_programming_permit_out,
   output logic                   priority_arb_enable_out,
   output logic                   accel_advertise_out,
   input  wire logic [DATA_W-1:0] tx_data_in,
   input  wire logic              tx_eop_in,
   input  wire logic              tx_valid_in,
   output logic                   tx_ready_out,
   input  wire logic [1:0]        link_phy_control_lines_in,
   output logic [1:0]             link_phy_control_lines_out,
   output logic                   link_phy_control_lines_oe_n_out,
   output logic                   link_request_out,
   output logic [DATA_W-1:0]      link_data_out,
   output logic                   link_eop_out,
   output logic                   link_valid_out,
   input  wire logic              link_ready_in,
   output logic                   underrun_out
);
   localparam int CW = $clog2(DEPTH) + 1;

   typedef struct packed {
      lfte_state_t       state;
      logic [1:0]        thresh;
      logic              prio_en;
      logic              idle_en;
      logic              accel_en;
      logic              permit;
      logic              sf_retry;
      logic [CW-1:0]     eop_cnt;
      logic [31:0]       rdata;
      logic [DATA_W-1:0] data;
      logic              eop;
      logic              valid;
      logic              underrun;
      logic              request;
      logic              oe_n;
      logic [1:0]        ct;
      logic              prio_out;
      logic              accel_out;
   } lfte_ctrl_state_t;

   lfte_ctrl_state_t s_reg;
   lfte_ctrl_state_t s_next;

   logic              q_ready;
   logic              q_valid;
   logic              q_pop;
   logic [DATA_W:0]   q_word;
   logic [CW-1:0]     q_level;
   logic              q_push_eop;
   logic              q_pop_eop;
   logic              sf_mode;
   logic              start_ok;
   logic              can_take;
   logic [31:0]       reg_view;

   ////////////////////////////////////////////////////////////////////////////
   // Functions

   // Nominal byte level scaled onto the real queue depth, rounded up, never 0
   function automatic logic [CW-1:0] thr_words(input logic [1:0] sel);
      int bytes;
      int words;
      case (sel)
         `LFTE_THR_2K:  bytes = `LFTE_THR_2K_BYTES;
         `LFTE_THR_1K7: bytes = `LFTE_THR_1K7_BYTES;
         `LFTE_THR_1K:  bytes = `LFTE_THR_1K_BYTES;
         `LFTE_THR_512: bytes = `LFTE_THR_512_BYTES;
         default:       bytes = `LFTE_THR_2K_BYTES;
      endcase
      words = (bytes * DEPTH + `LFTE_QUEUE_NOMINAL_BYTES - 1) / `LFTE_QUEUE_NOMINAL_BYTES;
      if (words < 1) begin
         words = 1;
      end
      return CW'(words);
   endfunction

   // Driving states own the control and data lines
   function automatic logic drives_lines(input lfte_state_t st);
      return (st == st_drive) || (st == st_fin);
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // Transmit queue

   lfte_fifo #(
      .WIDTH (DATA_W + 1),
      .DEPTH (DEPTH)
   ) u_queue (
      .clk_in        (clk_in),
      .rst_in        (rst_in),
      .in_valid_in   (tx_valid_in),
      .in_ready_out  (q_ready),
      .in_data_in    ({tx_eop_in, tx_data_in}),
      .out_valid_out (q_valid),
      .out_ready_in  (q_pop),
      .out_data_out  (q_word),
      .level_out     (q_level)
   );

   assign q_push_eop = tx_valid_in && q_ready && tx_eop_in;
   assign q_pop_eop  = q_pop && q_word[DATA_W];
   assign can_take   = !s_reg.valid || link_ready_in;

   // Without the gate the stored threshold is ignored and packets go out whole
   assign sf_mode = !phy_enhancement_gate_in ||
                    s_reg.sf_retry ||
                    (s_reg.thresh == `LFTE_THR_2K);

   // A queued end-of-packet always allows a start; the level only below 2K
   assign start_ok = (s_reg.eop_cnt != '0) ||
                     (!sf_mode && (q_level >= thr_words(s_reg.thresh)));

   always_comb begin
      q_pop = 1'b0;
      case (s_reg.state)
         st_drive:   q_pop = can_take && q_valid;
         st_discard: q_pop = q_valid;
         default:    q_pop = 1'b0;
      endcase
   end

   // Read view: reserved bits and bit 6 read as zero
   always_comb begin
      reg_view = '0;
      reg_view[`LFTE_THRESH_HI:`LFTE_THRESH_LO] = s_reg.thresh;
      reg_view[`LFTE_PRIO_BIT]  = s_reg.prio_en;
      reg_view[`LFTE_IDLE_BIT]  = s_reg.idle_en;
      reg_view[`LFTE_ACCEL_BIT] = s_reg.accel_en;
   end

   ////////////////////////////////////////////////////////////////////////////
   // Next state

   always_comb begin
      s_next          = s_reg;
      s_next.underrun = 1'b0;

      // Register loading; a ROM load in the same cycle as a write wins
      if (rom_load_in) begin
         s_next.thresh   = rom_word_in[`LFTE_THRESH_HI:`LFTE_THRESH_LO];
         s_next.prio_en  = rom_word_in[`LFTE_PRIO_BIT];
         s_next.idle_en  = rom_word_in[`LFTE_IDLE_BIT];
         s_next.accel_en = rom_word_in[`LFTE_ACCEL_BIT];
         s_next.permit   = rom_word_in[`LFTE_PERMIT_BIT];
      end else if (cfg_wr_in && (cfg_addr_in == `LFTE_LINK_FEATURE_TUNING_OFS)) begin
         // Only writable bits are taken; reserved and bit 6 writes are lost
         s_next.thresh   = cfg_wdata_in[`LFTE_THRESH_HI:`LFTE_THRESH_LO];
         s_next.prio_en  = cfg_wdata_in[`LFTE_PRIO_BIT];
         s_next.idle_en  = cfg_wdata_in[`LFTE_IDLE_BIT];
         s_next.accel_en = cfg_wdata_in[`LFTE_ACCEL_BIT];
      end

      if (cfg_rd_in) begin
         if (cfg_addr_in == `LFTE_LINK_FEATURE_TUNING_OFS) begin
            s_next.rdata = reg_view;
         end else begin
            s_next.rdata = '0;
         end
      end

      // Count of whole packets held in the queue
      s_next.eop_cnt = s_reg.eop_cnt + CW'(q_push_eop) - CW'(q_pop_eop);

      if (link_ready_in) begin
         s_next.valid = 1'b0;
      end

      case (s_reg.state)
         st_idle: begin
            // Decision taken here only, so a later threshold write cannot touch it
            if (start_ok) begin
               s_next.state = st_req;
            end
         end
         st_req: begin
            if (link_phy_control_lines_in == `LFTE_CT_GRANT) begin
               if (phy_enhancement_gate_in && s_reg.idle_en) begin
                  s_next.state = st_turn;
               end else begin
                  s_next.state = st_drive;
               end
            end
         end
         st_turn: begin
            s_next.state = st_drive;
         end
         st_drive: begin
            if (can_take) begin
               if (q_valid) begin
                  s_next.data  = q_word[DATA_W-1:0];
                  s_next.eop   = q_word[DATA_W];
                  s_next.valid = 1'b1;
                  if (q_word[DATA_W]) begin
                     s_next.state = st_fin;
                  end
               end else begin
                  // Queue ran dry before end-of-packet: abandon and retry whole
                  s_next.underrun = 1'b1;
                  s_next.sf_retry = 1'b1;
                  s_next.state    = st_discard;
               end
            end
         end
         st_fin: begin
            if (link_ready_in) begin
               s_next.sf_retry = 1'b0;
               s_next.state    = st_idle;
            end
         end
         st_discard: begin
            // Rest of the failed packet is dropped; the source resends it
            if (q_pop_eop) begin
               s_next.state = st_idle;
            end
         end
         default: begin
            s_next.state = st_idle;
         end
      endcase

      s_next.request   = (s_next.state == st_req);
      s_next.oe_n      = !drives_lines(s_next.state);
      s_next.ct        = drives_lines(s_next.state) ? `LFTE_CT_XMIT : 2'h0;
      s_next.prio_out  = phy_enhancement_gate_in && s_next.prio_en;
      s_next.accel_out = phy_enhancement_gate_in && s_next.accel_en;
   end

   ////////////////////////////////////////////////////////////////////////////
   // State register

   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         s_reg           <= '0;
         s_reg.state     <= st_idle;
         s_reg.thresh    <= `LFTE_THR_1K7;
         s_reg.oe_n      <= 1'b1;
      end else begin
         s_reg <= s_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Outputs

   assign cfg_rdata_out                   = s_reg.rdata;
   assign phy_programming_permit_out      = s_reg.permit;
   assign priority_arb_enable_out         = s_reg.prio_out;
   assign accel_advertise_out             = s_reg.accel_out;
   assign tx_ready_out                    = q_ready;
   assign link_phy_control_lines_out      = s_reg.ct;
   assign link_phy_control_lines_oe_n_out = s_reg.oe_n;
   assign link_request_out                = s_reg.request;
   assign link_data_out                   = s_reg.data;
   assign link_eop_out                    = s_reg.eop;
   assign link_valid_out                  = s_reg.valid;
   assign underrun_out                    = s_reg.underrun;

endmodule // lfte_ctrl

`default_nettype wire

// ### tb/lfte_phy_model.sv
// Far-side partner: grants the link the control lines on request
`timescale 1ns/10ps
`default_nettype none

module lfte_phy_model (
   input  wire logic       clk_in,
   input  wire logic       rst_in,
   input  wire logic       link_request_in,
   input  wire logic [2:0] grant_delay_in,
   output logic            grant_out
);
   logic [2:0] wait_reg;

   // Grant stands one cycle only, so the lines are free before the link drives
   always_ff @(posedge clk_in) begin
      if (rst_in || grant_out) begin
         grant_out <= 1'b0;
         wait_reg  <= 3'h0;
      end else if (link_request_in && wait_reg >= grant_delay_in) begin
         grant_out <= 1'b1;
      end else begin
         wait_reg <= link_request_in ? wait_reg + 3'h1 : 3'h0;
      end
   end
endmodule // lfte_phy_model

`default_nettype wire

// ### tb/lfte_ctrl_monitor.sv
// Port-level assertions for the link feature tuning block
`timescale 1ns/10ps
`default_nettype none
`include "lfte_defs.svh"

module lfte_ctrl_monitor (
   input wire logic        clk_in,
   input wire logic        rst_in,
   input wire logic [7:0]  cfg_addr_in,
   input wire logic        cfg_wr_in,
   input wire logic        cfg_rd_in,
   input wire logic [31:0] cfg_wdata_in,
   input wire logic [31:0] cfg_rdata_out,
   input wire logic        rom_load_in,
   input wire logic [31:0] rom_word_in,
   input wire logic        phy_enhancement_gate_in,
   input wire logic        phy_programming_permit_out,
   input wire logic        priority_arb_enable_out,
   input wire logic        accel_advertise_out,
   input wire logic [1:0]  link_phy_control_lines_in,
   input wire logic [1:0]  link_phy_control_lines_out,
   input wire logic        link_phy_control_lines_oe_n_out,
   input wire logic        link_request_out,
   input wire logic        link_valid_out,
   input wire logic        link_ready_in,
   input wire logic        underrun_out
);
   logic      idle_reg;
   wire logic idle_on = idle_reg & phy_enhancement_gate_in;

   // Shadow of the turnaround bit, so grant timing is judged from the ports
   always_ff @(posedge clk_in) begin
      if (rst_in)
         idle_reg <= 1'b0;
      else if (rom_load_in)
         idle_reg <= rom_word_in[`LFTE_IDLE_BIT];
      else if (cfg_wr_in && cfg_addr_in == `LFTE_LINK_FEATURE_TUNING_OFS)
         idle_reg <= cfg_wdata_in[`LFTE_IDLE_BIT];
   end

   default clocking cb @(posedge clk_in); endclocking
   default disable iff (rst_in);

   sequence s_grant;
      link_request_out && link_phy_control_lines_in == `LFTE_CT_GRANT;
   endsequence
   sequence s_hit;
      cfg_rd_in && cfg_addr_in == `LFTE_LINK_FEATURE_TUNING_OFS;
   endsequence

   a_grant_direct: assert property (s_grant ##0 !idle_on |=> !link_phy_control_lines_oe_n_out)
      else $error("link late after grant");
   a_grant_turnaround: assert property (s_grant ##0 idle_on |=> link_phy_control_lines_oe_n_out
      ##1 !link_phy_control_lines_oe_n_out)
      else $error("turnaround cycle wrong");
   a_request_held: assert property (link_request_out &&
      link_phy_control_lines_in != `LFTE_CT_GRANT |=> link_request_out)
      else $error("request dropped before grant");
   a_drive_code: assert property (!link_phy_control_lines_oe_n_out |->
      link_phy_control_lines_out == `LFTE_CT_XMIT)
      else $error("wrong control code while driving");
   a_reserved_zero: assert property (s_hit |=>
      (cfg_rdata_out & ~`LFTE_LINK_FEATURE_TUNING_WMASK) == 32'h0)
      else $error("reserved bits not zero");
   a_unmapped_zero: assert property (cfg_rd_in &&
      cfg_addr_in != `LFTE_LINK_FEATURE_TUNING_OFS |=> cfg_rdata_out == 32'h0)
      else $error("unmapped read not zero");
   a_prio_gated: assert property (!phy_enhancement_gate_in |=> !priority_arb_enable_out)
      else $error("priority enable while gate low");
   a_accel_gated: assert property (!phy_enhancement_gate_in |=> !accel_advertise_out)
      else $error("accel advertised while gate low");
   a_permit_load: assert property (rom_load_in |=>
      phy_programming_permit_out == $past(rom_word_in[`LFTE_PERMIT_BIT]))
      else $error("permit not loaded");
   a_underrun_pulse: assert property (underrun_out |=> !underrun_out
      && link_phy_control_lines_oe_n_out)
      else $error("underrun not a pulse with release");
   a_valid_hold: assert property (link_valid_out && !link_ready_in |=> link_valid_out)
      else $error("word withdrawn unaccepted");
endmodule // lfte_ctrl_monitor

bind lfte_ctrl lfte_ctrl_monitor i_lfte_ctrl_monitor (.clk_in(clk_in), .rst_in(rst_in),
   .cfg_addr_in(cfg_addr_in), .cfg_wr_in(cfg_wr_in), .cfg_rd_in(cfg_rd_in),
   .cfg_wdata_in(cfg_wdata_in), .cfg_rdata_out(cfg_rdata_out), .rom_load_in(rom_load_in),
   .rom_word_in(rom_word_in), .phy_enhancement_gate_in(phy_enhancement_gate_in),
   .phy_programming_permit_out(phy_programming_permit_out),
   .priority_arb_enable_out(priority_arb_enable_out), .accel_advertise_out(accel_advertise_out),
   .link_phy_control_lines_in(link_phy_control_lines_in),
   .link_phy_control_lines_out(link_phy_control_lines_out),
   .link_phy_control_lines_oe_n_out(link_phy_control_lines_oe_n_out),
   .link_request_out(link_request_out), .link_valid_out(link_valid_out),
   .link_ready_in(link_ready_in), .underrun_out(underrun_out));

`default_nettype wire

// ### tb/link_enhancement_control_test.sv
// Self-checking bench for the link feature tuning block
`timescale 1ns/10ps
`default_nettype none
`include "lfte_defs.svh"

module link_enhancement_control_test;
   logic        clk_in = 1'b0, rst_in = 1'b1, wr = 1'b0, rd = 1'b0, rom_ld = 1'b0, gate = 1'b0;
   logic [7:0]  addr = 8'h00;
   logic [31:0] wdata = 32'h0, rom_word = 32'h0, tx_data = 32'h0, rdata, l_data;
   logic        tx_eop = 1'b0, tx_valid = 1'b0, l_ready = 1'b0, tx_ready, permit, prio, accel;
   logic        req, oe_n, l_eop, l_valid, underrun, grant;
   logic [1:0]  ct_out, ct_last;
   logic [2:0]  grant_delay = 3'h0;
   logic [32:0] rx_q[$], exp_q[$];
   int          miscompares = 0, total_checks = 0, retry = 0, req_cnt = 0, under_cnt = 0;
   int unsigned rng = 10617;
   int          thr[4] = '{16, 14, 8, 4};
   // Released lines show the inverse of their last driven value, never a false grant
   wire logic [1:0] ct_wire = rst_in ? 2'h0 : grant ? 2'h3 : !oe_n ? ct_out : ~ct_last;

   always #2.5 clk_in = ~clk_in;

   lfte_ctrl #(.DATA_W(32), .DEPTH(16)) i_lfte_ctrl (.clk_in(clk_in), .rst_in(rst_in),
      .cfg_addr_in(addr), .cfg_wr_in(wr), .cfg_rd_in(rd), .cfg_wdata_in(wdata),
      .cfg_rdata_out(rdata), .rom_load_in(rom_ld), .rom_word_in(rom_word),
      .phy_enhancement_gate_in(gate), .phy_programming_permit_out(permit),
      .priority_arb_enable_out(prio), .accel_advertise_out(accel), .tx_data_in(tx_data),
      .tx_eop_in(tx_eop), .tx_valid_in(tx_valid), .tx_ready_out(tx_ready),
      .link_phy_control_lines_in(ct_wire), .link_phy_control_lines_out(ct_out),
      .link_phy_control_lines_oe_n_out(oe_n), .link_request_out(req), .link_data_out(l_data),
      .link_eop_out(l_eop), .link_valid_out(l_valid), .link_ready_in(l_ready),
      .underrun_out(underrun));
   lfte_phy_model i_lfte_phy_model (.clk_in(clk_in), .rst_in(rst_in), .link_request_in(req),
      .grant_delay_in(grant_delay), .grant_out(grant));

   function automatic logic [31:0] next_rand();
      rng ^= rng << 13;
      rng ^= rng >> 17;
      rng ^= rng << 5;
      return rng;
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   always @(posedge clk_in) begin
      logic [31:0] r;
      r = next_rand();
      if (l_valid && l_ready) rx_q.push_back({l_eop, l_data});
      // Counters have one driver; scenarios compare against a snapshot
      if (req) req_cnt <= req_cnt + 1;
      if (underrun) under_cnt <= under_cnt + 1;
      if (rst_in) ct_last <= 2'h3;
      else if (grant || !oe_n) ct_last <= ct_wire;
      grant_delay <= r[2:0];
      l_ready     <= r[4:3] != 2'h0;
   end

   task automatic check(input string name, input logic [32:0] seen, input logic [32:0] exp);
      total_checks++;
      if (seen !== exp) begin
         miscompares++;
         $display("ERROR %s expected %h seen %h", name, exp, seen);
      end
   endtask

   task automatic conclude();
      $display("checks %0d mismatches %0d", total_checks, miscompares);
      if (miscompares == 0 && total_checks > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask

   task automatic cfg_read(input logic [7:0] a, input logic [31:0] exp, input string name);
      addr <= a;
      rd   <= 1'b1;
      @(posedge clk_in);
      rd <= 1'b0;
      #1 check(name, 33'(rdata), 33'(exp));
      @(posedge clk_in);
   endtask

   task automatic cfg_write(input logic [31:0] d);
      addr  <= `LFTE_LINK_FEATURE_TUNING_OFS;
      wdata <= d;
      wr    <= 1'b1;
      @(posedge clk_in);
      wr <= 1'b0;
      @(posedge clk_in);
   endtask

   // Holds the word until the queue takes it
   task automatic push_word(input logic eop);
      int          n;
      logic [31:0] d;
      d = next_rand();
      tx_data  <= d;
      tx_eop   <= eop;
      tx_valid <= 1'b1;
      exp_q.push_back({eop, d});
      for (n = 0; n < 200; n++) begin
         @(negedge clk_in);
         if (tx_ready === 1'b1) break;
      end
      if (n == 200) begin
         miscompares++;
         conclude();
      end
      @(posedge clk_in);
   endtask

   ////////////////////////////////////////////////////////////////////////////
   initial begin
      logic [1:0]  code;
      logic [31:0] w;
      logic        exp_start;
      int          kk[9] = '{4, 14, 13, 8, 7, 4, 4, 4, 4};
      int          cd[9] = '{0, 1, 1, 2, 2, 3, 3, 3, 3};
      int          gt[9] = '{1, 1, 1, 1, 1, 0, 1, 1, 1};
      int          st[9] = '{5, 5, 5, 5, 5, 5, 40, 5, 5};
      int          req_base, under_base, n;
      repeat (8) @(posedge clk_in);
      rst_in <= 1'b0;
      @(posedge clk_in);
      cfg_read(8'hf4, `LFTE_LINK_FEATURE_TUNING_RST, "reset value");
      cfg_read(8'hf8, 32'h0, "unmapped read");
      cfg_write(32'hffffffff);
      cfg_read(8'hf4, `LFTE_LINK_FEATURE_TUNING_WMASK, "writable bits");
      // ROM load and host write in one cycle: the ROM word must win
      rom_word <= 32'hffffcfff;
      rom_ld   <= 1'b1;
      wr       <= 1'b1;
      wdata    <= 32'h0;
      @(posedge clk_in);
      rom_ld <= 1'b0;
      wr     <= 1'b0;
      @(posedge clk_in);
      cfg_read(8'hf4, 32'hffffcfff & `LFTE_LINK_FEATURE_TUNING_WMASK, "rom load");
      check("permit", 33'(permit), 33'h1);
      cfg_write(32'h0);
      check("permit kept", 33'(permit), 33'h1);
      for (int i = 0; i < 9; i++) begin
         code = 2'(cd[i]);
         w    = {18'h0, code, 4'h0, 1'b1, 4'h0, code[0], 2'h2};
         gate <= gt[i][0];
         cfg_write(w);
         check("priority enable", 33'(prio), 33'(gt[i]));
         check("accel advertise", 33'(accel), 33'(gt[i]));
         cfg_read(8'hf4, w, "threshold field");
         exp_start = gt[i] == 1 && code != 2'h0 && retry == 0 && kk[i] >= thr[code];
         req_base   = req_cnt;
         under_base = under_cnt;
         repeat (kk[i]) push_word(1'b0);
         tx_valid <= 1'b0;
         repeat (st[i]) @(posedge clk_in);
         @(negedge clk_in);
         check("early start", 33'(req_cnt != req_base), 33'(exp_start));
         @(posedge clk_in);
         push_word(1'b1);
         tx_valid <= 1'b0;
         tx_eop   <= 1'b0;
         for (n = 0; n < 400 && under_cnt == under_base && rx_q.size() < exp_q.size(); n++)
            @(posedge clk_in);
         if (n == 400) begin
            miscompares++;
            conclude();
         end
         check("underrun", 33'(under_cnt != under_base), 33'(st[i] > 30));
         if (under_cnt != under_base) begin
            retry = 1;
            rx_q.delete();
            exp_q.delete();
         end else begin
            retry = 0;
            check("word count", 33'(rx_q.size()), 33'(exp_q.size()));
            foreach (exp_q[j]) check("link word", rx_q[j], exp_q[j]);
            rx_q.delete();
            exp_q.delete();
         end
      end
      cfg_write(`LFTE_LINK_FEATURE_TUNING_RST);
      conclude();
   end
endmodule // link_enhancement_control_test

`default_nettype wire
